// ===== pkg/fica_pkg.sv
// How it works
// [R1] writing one to the pending bit starts one fabric access at the target index
// [R2] pending stays set during the access and clears itself when it completes
// [R3] software leaves command and value alone while pending is set
// [R4] direction zero writes the fabric register, one reads it
// [R5] step-up: a value write starts a fabric write, then the index goes up one
// [R6] step-up: a value read raises the index by one and starts the next fabric read
// [R7] step-down: a value write starts a fabric write, then the index goes down one
// [R8] step-down: a value read lowers the index by one and starts the next fabric read
// [R9] with both step bits set, only step-up acts
// [R10] software clears the step bit before its last value read
// [R11] lane bit n selects data byte n of the fabric register
// [R12] unselected bytes stay unchanged in the fabric register on a write
// [R13] software sets all four lanes when it uses stepping
// [R14] the target field holds the 16-bit index of the next access
// [R15] a value read returns fabric data if direction is one, else the last host write
// [R16] bits 27 to 20 read zero and ignore writes; all fields reset to zero
package fica_pkg;

  localparam int          ADDR_W       = 12;
  localparam logic [11:0] OFFSET_VALUE = 12'h1AC;
  localparam logic [11:0] OFFSET_CMD   = 12'h1B0;

  localparam int PENDING_BIT   = 31;
  localparam int DIRECTION_BIT = 30;
  localparam int STEP_UP_BIT   = 29;
  localparam int STEP_DOWN_BIT = 28;
  localparam int RSVD_MSB      = 27;
  localparam int RSVD_LSB      = 20;
  localparam int LANE_MSB      = 19;
  localparam int LANE_LSB      = 16;
  localparam int INDEX_MSB     = 15;
  localparam int INDEX_LSB     = 0;

  localparam logic [7:0]  RSVD_VALUE   = 8'h00;
  localparam logic [3:0]  LANE_RESET   = 4'h0;
  localparam logic [15:0] INDEX_RESET  = 16'h0000;
  localparam logic [15:0] INDEX_STEP   = 16'h0001;
  localparam logic [31:0] VALUE_RESET  = 32'h00000000;

  typedef struct packed {
    logic        write;
    logic [3:0]  lanes;
    logic [15:0] index;
    logic [31:0] wdata;
  } fica_fab_req_t;

  localparam fica_fab_req_t REQ_RESET = '{1'b0, 4'h0, 16'h0000, 32'h00000000};

endpackage

// ===== hdl/fica_fabric_port.sv
`timescale 1ns/1ps
module fica_fabric_port (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    launch,
  input  fica_pkg::fica_fab_req_t      cmd,
  input  wire logic                    fab_ack,
  input  wire logic [31:0]             fab_rdata,
  output logic                         fab_valid,
  output fica_pkg::fica_fab_req_t      fab_req,
  output logic                         done,
  output logic [31:0]                  rdata
);

  typedef enum {FICA_ST_IDLE, FICA_ST_WAIT} fica_port_state_t;

  fica_port_state_t        state_reg;
  fica_port_state_t        state_next;
  logic                    valid_reg;
  fica_pkg::fica_fab_req_t req_reg;
  logic                    done_reg;
  logic [31:0]             rdata_reg;

  wire take = (state_reg == FICA_ST_IDLE) & launch;
  wire fin  = (state_reg == FICA_ST_WAIT) & fab_ack;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FICA_ST_IDLE: if (launch) state_next = FICA_ST_WAIT;
      FICA_ST_WAIT: if (fab_ack) state_next = FICA_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= FICA_ST_IDLE;
      valid_reg <= 1'b0;
      req_reg   <= fica_pkg::REQ_RESET;
      done_reg  <= 1'b0;
      rdata_reg <= fica_pkg::VALUE_RESET;
    end else begin
      state_reg <= state_next;
      valid_reg <= take | (valid_reg & ~fin);
      done_reg  <= fin;
      if (take) req_reg <= cmd;
      if (fin && !req_reg.write) rdata_reg <= fab_rdata;
    end
  end

  assign fab_valid = valid_reg;
  assign fab_req   = req_reg;
  assign done      = done_reg;
  assign rdata     = rdata_reg;

endmodule

// ===== hdl/fica_top.sv
`timescale 1ns/1ps
module fica_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         fab_valid,
  output fica_pkg::fica_fab_req_t      fab_req,
  input  wire logic                    fab_ack,
  input  wire logic [31:0]             fab_rdata
);

  // command register fields
  logic        access_pending_reg;
  logic        access_pending_next;
  logic        direction_select_reg;
  logic        step_up_enable_reg;
  logic        step_down_enable_reg;
  logic [3:0]  lane_select_reg;
  logic [15:0] target_index_reg;
  logic [15:0] target_index_next;

  // value register: last host write; fabric read data lives in the port
  logic [31:0] host_value_reg;

  // apb answer
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;

  logic        launch_reg;

  wire         port_done;
  wire [31:0]  port_rdata;

  // bus decode
  wire apb_access = psel & penable;
  wire apb_first  = apb_access & ~pready_reg;
  wire apb_done   = apb_access & pready_reg;
  wire wr_done    = apb_done & pwrite;
  wire rd_done    = apb_done & ~pwrite;

  wire hit_value  = (paddr == fica_pkg::OFFSET_VALUE);
  wire hit_cmd    = (paddr == fica_pkg::OFFSET_CMD);
  wire hit_none   = ~(hit_value | hit_cmd);

  wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  wire [31:0] cmd_view = {access_pending_reg,
                          direction_select_reg,
                          step_up_enable_reg,
                          step_down_enable_reg,
                          fica_pkg::RSVD_VALUE, // [R16]
                          lane_select_reg,
                          target_index_reg};

  wire [31:0] cmd_merged   = (cmd_view & ~wmask) | (pwdata & wmask);
  wire [31:0] value_merged = (host_value_reg & ~wmask) | (pwdata & wmask);

  // while an access runs, host changes to command or value are dropped
  wire cmd_write   = wr_done & hit_cmd & ~access_pending_reg; // [R3]
  wire value_write = wr_done & hit_value & ~access_pending_reg; // [R3]
  wire value_read  = rd_done & hit_value & ~access_pending_reg;

  wire step_any    = step_up_enable_reg | step_down_enable_reg;

  // step-up wins when both are set
  wire [15:0] index_stepped = step_up_enable_reg ? // [R9]
                              16'(target_index_reg + fica_pkg::INDEX_STEP) : // [R5] [R6]
                              16'(target_index_reg - fica_pkg::INDEX_STEP); // [R7] [R8]

  wire cmd_start        = cmd_write & cmd_merged[fica_pkg::PENDING_BIT]; // [R1]
  wire auto_write_start = value_write & step_any; // [R5] [R7]
  wire auto_read_start  = value_read & step_any; // [R6] [R8]
  wire start            = cmd_start | auto_write_start | auto_read_start;

  wire write_finished   = port_done & fab_req.write;
  wire post_step        = write_finished & step_any; // [R5] [R7]

  // value read source follows direction
  wire [31:0] value_view = direction_select_reg ? port_rdata : host_value_reg; // [R15]

  wire [31:0] read_mux = hit_value ? value_view :
                         hit_cmd   ? cmd_view   :
                                     32'h00000000;

  // launch request built from the registers one cycle after start
  wire fica_pkg::fica_fab_req_t launch_cmd = '{
    write: ~direction_select_reg, // [R4]
    lanes: lane_select_reg,       // [R11] [R12]
    index: target_index_reg,      // [R14]
    wdata: host_value_reg
  };

  // pending is set by a start and cleared by completion; set wins
  always_comb begin
    access_pending_next = access_pending_reg;
    if (port_done) access_pending_next = 1'b0; // [R2]
    if (start) access_pending_next = 1'b1; // [R1]
  end

  always_comb begin
    target_index_next = target_index_reg;
    if (cmd_write) begin
      target_index_next = cmd_merged[fica_pkg::INDEX_MSB:fica_pkg::INDEX_LSB]; // [R14]
    end else if (auto_read_start || post_step) begin
      target_index_next = index_stepped; // [R5] [R6] [R7] [R8]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_pending_reg <= 1'b0; // [R16]
      target_index_reg   <= fica_pkg::INDEX_RESET;
      launch_reg         <= 1'b0;
    end else begin
      access_pending_reg <= access_pending_next;
      target_index_reg   <= target_index_next;
      launch_reg         <= start;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction_select_reg <= 1'b0;
      step_up_enable_reg   <= 1'b0;
      step_down_enable_reg <= 1'b0;
      lane_select_reg      <= fica_pkg::LANE_RESET;
    end else if (cmd_write) begin
      direction_select_reg <= cmd_merged[fica_pkg::DIRECTION_BIT]; // [R4]
      step_up_enable_reg   <= cmd_merged[fica_pkg::STEP_UP_BIT];
      step_down_enable_reg <= cmd_merged[fica_pkg::STEP_DOWN_BIT];
      lane_select_reg      <= cmd_merged[fica_pkg::LANE_MSB:fica_pkg::LANE_LSB]; // [R11]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_value_reg <= fica_pkg::VALUE_RESET;
    end else if (value_write) begin
      host_value_reg <= value_merged; // [R15]
    end
  end

  // one wait state: answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= apb_first;
      pslverr_reg <= apb_first & hit_none;
      if (apb_first && !pwrite) prdata_reg <= read_mux;
    end
  end

  fica_fabric_port u_port (
    .pclk      (pclk),
    .presetn   (presetn),
    .launch    (launch_reg),
    .cmd       (launch_cmd),
    .fab_ack   (fab_ack),
    .fab_rdata (fab_rdata),
    .fab_valid (fab_valid),
    .fab_req   (fab_req),
    .done      (port_done),
    .rdata     (port_rdata)
  );

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // checks

  sequence seq_launch;
    launch_reg ##1 fab_valid;
  endsequence

  sequence seq_step_up_read;
    auto_read_start && step_up_enable_reg;
  endsequence

  sequence seq_step_down_read;
    auto_read_start && !step_up_enable_reg && step_down_enable_reg;
  endsequence

  a_start_sets_pending: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    start |=> access_pending_reg ##0 seq_launch
  ) else $error("start did not set pending and launch an access");

  a_pending_holds: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    access_pending_reg && !port_done |=> access_pending_reg
  ) else $error("pending dropped before completion");

  sequence seq_fabric_done;
    fab_valid && fab_ack;
  endsequence

  a_pending_clears: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    seq_fabric_done |=> ##1 !access_pending_reg
  ) else $error("pending not cleared after fabric answer");

  a_read_data_ready: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    $fell(access_pending_reg) && !fab_req.write |-> port_rdata == $past(fab_rdata, 2)
  ) else $error("read data not held when pending cleared");

  a_direction_map: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    fab_valid |-> fab_req.write == !direction_select_reg
  ) else $error("access direction does not match direction bit");

  a_step_up_write: assert property ( // [R5]
    @(posedge pclk) disable iff (!presetn)
    write_finished && step_up_enable_reg
      |=> target_index_reg == 16'($past(target_index_reg) + 16'h0001)
  ) else $error("index not raised after stepped write");

  a_step_up_read: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    seq_step_up_read
      |=> target_index_reg == 16'($past(target_index_reg) + 16'h0001) ##0 seq_launch
  ) else $error("stepped read did not raise index and launch");

  a_step_down_write: assert property ( // [R7]
    @(posedge pclk) disable iff (!presetn)
    write_finished && !step_up_enable_reg && step_down_enable_reg
      |=> target_index_reg == 16'($past(target_index_reg) - 16'h0001)
  ) else $error("index not lowered after stepped write");

  a_step_down_read: assert property ( // [R8]
    @(posedge pclk) disable iff (!presetn)
    seq_step_down_read
      |=> target_index_reg == 16'($past(target_index_reg) - 16'h0001) ##0 seq_launch
  ) else $error("stepped read did not lower index and launch");

  a_both_steps_up: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    auto_read_start && step_up_enable_reg && step_down_enable_reg
      |=> target_index_reg == 16'($past(target_index_reg) + 16'h0001)
  ) else $error("step-up did not take precedence");

  a_lane_pass: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
    fab_valid |-> fab_req.lanes == lane_select_reg
  ) else $error("lanes on fabric differ from lane select");

  a_index_pass: assert property ( // [R14]
    @(posedge pclk) disable iff (!presetn)
    $rose(fab_valid) |-> fab_req.index == target_index_reg
  ) else $error("fabric index differs from target index");

  a_value_source: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    apb_done && !pwrite && hit_value && !access_pending_reg && !launch_reg
      |-> prdata == (direction_select_reg ? port_rdata : host_value_reg)
  ) else $error("value read returned wrong source");

  a_reserved_zero: assert property ( // [R16]
    @(posedge pclk) disable iff (!presetn)
    apb_done && !pwrite && hit_cmd |-> prdata[27:20] == 8'h00
  ) else $error("reserved command bits read nonzero");

  a_busy_blocks: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    access_pending_reg && wr_done && hit_value |=> $stable(host_value_reg)
  ) else $error("value changed by a write while pending");

  a_cmd_no_start: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    cmd_write && !cmd_merged[fica_pkg::PENDING_BIT] |=> !access_pending_reg
  ) else $error("command write without pending bit started an access");

  a_auto_write_data: assert property ( // [R5] [R7]
    @(posedge pclk) disable iff (!presetn)
    auto_write_start |=> seq_launch ##0 fab_req.wdata == host_value_reg
  ) else $error("stepped value write did not launch with the new value");

  a_write_data_hold: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    fab_valid && fab_req.write |-> fab_req.wdata == host_value_reg
  ) else $error("fabric write data differs from the value register");

  a_index_hold: assert property ( // [R14]
    @(posedge pclk) disable iff (!presetn)
    !cmd_write && !auto_read_start && !post_step
      |=> $stable(target_index_reg)
  ) else $error("target index moved without a cause");

  a_cmd_sets_index: assert property ( // [R14]
    @(posedge pclk) disable iff (!presetn)
    cmd_write
      |=> target_index_reg == $past(cmd_merged[fica_pkg::INDEX_MSB:fica_pkg::INDEX_LSB])
  ) else $error("command write did not load the target index");

  a_cmd_sets_lanes: assert property ( // [R11]
    @(posedge pclk) disable iff (!presetn)
    cmd_write
      |=> lane_select_reg == $past(cmd_merged[fica_pkg::LANE_MSB:fica_pkg::LANE_LSB])
  ) else $error("command write did not load the lane select");

  a_cmd_sets_direction: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    cmd_write
      |=> direction_select_reg == $past(cmd_merged[fica_pkg::DIRECTION_BIT])
  ) else $error("command write did not load the direction");

  a_both_write_up: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    write_finished && step_up_enable_reg && step_down_enable_reg
      |=> target_index_reg == 16'($past(target_index_reg) + 16'h0001)
  ) else $error("step-up did not take precedence after a write");

  a_read_data_capture: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    seq_fabric_done && !fab_req.write |=> port_rdata == $past(fab_rdata)
  ) else $error("fabric read data not captured at the answer");

  a_plain_read_idle: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    value_read && !step_any |=> !access_pending_reg
  ) else $error("plain value read started an access");

  a_done_one_cycle: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    port_done |=> !port_done
  ) else $error("completion lasted more than one cycle");

  a_ready_one_cycle: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready
  ) else $error("bus ready lasted more than one cycle");

endmodule

// ===== sim/fica_fabric_model.sv
`timescale 1ns/1ps
module fica_fabric_model (
  input  wire logic               pclk,
  input  wire logic               fab_valid,
  input  fica_pkg::fica_fab_req_t fab_req,
  input  wire logic [3:0]         wait_cycles,
  output logic                    fab_ack,
  output logic [31:0]             fab_rdata
);
  logic [31:0] mem [256];
  logic [3:0]  cnt;
  logic [7:0]  ix;
  assign ix = fab_req.index[7:0];
  initial begin
    fab_ack = 1'b0;
    fab_rdata = 32'h00000000;
    cnt = 4'h0;
    for (int i = 0; i < 256; i++) mem[i] = 32'hC0DE0000 | i;
  end
  // answers after wait_cycles; read data line toggles when fab_valid is low and right after each answer, and holds while counting
  always @(posedge pclk) begin
    if (fab_valid && fab_ack) begin
      fab_ack <= 1'b0;
      cnt <= 4'h0;
      fab_rdata <= ~fab_rdata;
      if (fab_req.write)
        for (int b = 0; b < 4; b++)
          if (fab_req.lanes[b]) mem[ix][8*b +: 8] <= fab_req.wdata[8*b +: 8];
    end else if (fab_valid && cnt == wait_cycles) begin
      fab_ack <= 1'b1;
      fab_rdata <= mem[ix];
    end else if (fab_valid) cnt <= cnt + 4'h1;
    else fab_rdata <= ~fab_rdata;
  end
endmodule

// ===== sim/test_fabric_indirect_csr_access.sv
`timescale 1ns/1ps
module test_fabric_indirect_csr_access;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                    fab_valid, fab_ack, err;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, fab_rdata;
  logic [3:0]              pstrb, slow;
  fica_pkg::fica_fab_req_t fab_req;
  int                      mismatches, n_compared, cyc;
  localparam logic [11:0] CMD = fica_pkg::OFFSET_CMD;
  localparam logic [11:0] VAL = fica_pkg::OFFSET_VALUE;

  fica_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fab_valid(fab_valid), .fab_req(fab_req),
    .fab_ack(fab_ack), .fab_rdata(fab_rdata));
  fica_fabric_model fab (.pclk(pclk), .fab_valid(fab_valid), .fab_req(fab_req),
    .wait_cycles(slow), .fab_ack(fab_ack), .fab_rdata(fab_rdata));

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  function automatic logic [31:0] cw(logic [3:0] top, logic [3:0] ln, logic [15:0] ix);
    return {top, 8'h00, ln, ix};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // polls the command word so nothing is touched mid-access
  task automatic wait_idle();
    logic [31:0] q;
    q = 32'h80000000;
    while (q[31] !== 1'b0) apb(1'b0, CMD, 32'h0, q);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    apb(1'b0, CMD, 32'h0, q);
    chk(q, 32'h00000000);
    apb(1'b0, VAL, 32'h0, q);
    chk(q, 32'h00000000);
    apb(1'b1, CMD, 32'h7FFFFFFF, q);
    apb(1'b0, CMD, 32'h0, q);
    chk(q, 32'h700FFFFF);
    apb(1'b0, 12'h100, 32'h0, q);
    chk(q, 32'h00000000);
    chk({31'h0, err}, 32'h00000001);
    apb(1'b1, CMD, 32'h0, q);
    $display("test reset done");
  endtask

  task automatic t_write();
    logic [31:0] q;
    slow <= 4'h5;
    apb(1'b1, VAL, 32'h11223344, q);
    apb(1'b1, CMD, cw(4'h8, 4'h5, 16'h0005), q);
    apb(1'b0, CMD, 32'h0, q);
    chk(q, cw(4'h8, 4'h5, 16'h0005));
    wait_idle();
    chk(fab.mem[5], 32'hC0220044);
    $display("test write done");
  endtask

  task automatic t_read();
    logic [31:0] q;
    slow <= 4'h0;
    apb(1'b1, CMD, cw(4'hC, 4'h0, 16'h0007), q);
    wait_idle();
    apb(1'b0, VAL, 32'h0, q);
    chk(q, 32'hC0DE0007);
    apb(1'b1, CMD, cw(4'h0, 4'hF, 16'h0007), q);
    apb(1'b0, VAL, 32'h0, q);
    chk(q, 32'h11223344);
    $display("test read done");
  endtask

  task automatic t_step(input logic [1:0] m);
    logic [31:0] q;
    logic [15:0] n;
    n = (m == 2'b01) ? 16'hFFFF : 16'h0001;
    slow <= {2'b00, m};
    apb(1'b1, CMD, cw({2'b00, m}, 4'hF, 16'h0010), q);
    apb(1'b1, VAL, 32'hA50000F0 | m, q);
    wait_idle();
    chk(fab.mem[16], 32'hA50000F0 | m);
    apb(1'b0, CMD, 32'h0, q);
    chk(q, cw({2'b00, m}, 4'hF, 16'h0010 + n));
    apb(1'b1, CMD, cw({2'b11, m}, 4'hF, 16'h0020), q);
    wait_idle();
    apb(1'b0, VAL, 32'h0, q);
    chk(q, 32'hC0DE0020);
    apb(1'b0, CMD, 32'h0, q);
    chk(q & 32'h7FFFFFFF, cw({2'b01, m}, 4'hF, 16'h0020 + n));
    wait_idle();
    apb(1'b1, CMD, cw(4'h4, 4'hF, 16'h0020 + n), q);
    apb(1'b0, VAL, 32'h0, q);
    chk(q, 32'hC0DE0000 | (16'h0020 + n) & 32'hFF);
    apb(1'b0, CMD, 32'h0, q);
    chk(q, cw(4'h4, 4'hF, 16'h0020 + n));
    $display("test step mode %0d done", m);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    slow = 4'h0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_write();
    t_read();
    for (int m = 1; m < 4; m++) t_step(m[1:0]);
    print_verdict();
  end
endmodule
